// ### src/ecp_cfg.svh
// Constants for the MAC control port: addresses, field positions, timing.
// Assumes byte addressing on the host bus; included by ecp_stat_mem, ecp_mac_ctrl and the bench.
`ifndef ECP_CFG_SVH
`define ECP_CFG_SVH

// Host address decode (byte address bits 19:9 select the MAC window)
`define ECP_BASE_HI      11'h390
`define ECP_ADDR_W       20
// Register offsets from the MAC base
`define ECP_OFF_CTRL     9'h000
`define ECP_OFF_CONFIG   9'h004
`define ECP_OFF_STATUS   9'h008
`define ECP_OFF_TXSTAT   9'h014
`define ECP_OFF_IRQSTAT  9'h024
`define ECP_OFF_IRQSET   9'h028
`define ECP_OFF_IRQCLR   9'h02c
`define ECP_OFF_IRQMASK  9'h030
`define ECP_OFF_PHYMGMT  9'h034
`define ECP_OFF_RXPAUSE  9'h038
`define ECP_OFF_SA_LOW   9'h098
`define ECP_OFF_SA_HIGH  9'h09c
`define ECP_OFF_TXQUANT  9'h0bc
`define ECP_OFF_LINKST   9'h0c0
// Statistics counters window: offsets 0x100..0x11c
`define ECP_STAT_HIT     4'h8
`define ECP_STAT_N       8
// Network control field positions
`define ECP_CB_ZPAUSE    12
`define ECP_CB_PAUSE     11
`define ECP_CB_BP        8
`define ECP_CB_STWE      7
`define ECP_CB_STINC     6
`define ECP_CB_STCLR     5
`define ECP_CB_MPE       4
`define ECP_CB_TXEN      3
`define ECP_CB_RXEN      2
// Status field positions
`define ECP_SB_MDIO      1
`define ECP_SB_IDLE      2
// Reset value of the configuration register (MDC divider field = 2)
`define ECP_CONFIG_RST   32'h0000_0800
// MDC timing: half period of at least 200 ns on an 8 ns clock
`define ECP_MDC_HALF_NS  200
`define ECP_CLK_NS       8
`define ECP_MGMT_BITS    6'h20

`endif

// ### src/ecp_pkg.sv
// Types shared by the MAC control port modules.
// Assumes ecp_cfg.svh holds the numeric constants.
package ecp_pkg;
	// PHY management shifter states
	typedef enum logic {
		ECP_MG_IDLE,
		ECP_MG_SHIFT
	} ecp_mgmt_state_t;
endpackage

// ### src/ecp_stat_mem.sv
// Statistics counter bank with registered read port.
// Assumes the caller gates host writes with the counter write enable.
`timescale 1ns/1ns
`default_nettype none
`include "ecp_cfg.svh"

module ecp_stat_mem
	import ecp_pkg::*;
(
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset_n,
	// Test commands
	input  wire logic                    clear_all,
	input  wire logic                    inc_all,
	// Host write and read
	input  wire logic                    wr_en,
	input  wire logic [2:0]              wr_idx,
	input  wire logic [31:0]             wr_data,
	input  wire logic [2:0]              rd_idx,
	output logic      [31:0]             rd_data,
	// MAC count events, one per counter
	input  wire logic [`ECP_STAT_N-1:0]  evt
);
	logic [31:0] cnt_reg [`ECP_STAT_N];

	// Clear beats a host write, which beats counting
	genvar gi;
	generate
		for (gi = 0; gi < `ECP_STAT_N; gi++) begin : g_cnt
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n)
					cnt_reg[gi] <= 32'h0;
				else if (clear_all)
					cnt_reg[gi] <= 32'h0;
				else if (wr_en && wr_idx == 3'(gi))
					cnt_reg[gi] <= wr_data;
				else if (inc_all || evt[gi])
					cnt_reg[gi] <= cnt_reg[gi] + 32'h1;
			end
		end
	endgenerate

	// Read data from a register so the port has one fixed latency
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			rd_data <= 32'h0;
		else
			rd_data <= cnt_reg[rd_idx];
	end
endmodule // ecp_stat_mem
`default_nettype wire

// ### src/ecp_mac_ctrl.sv
// Register front end of a 10/100 MAC: host bus, control, PHY management.
// Assumes a synchronous host bus with one-cycle rd/wr strobes on sys_clk.
// Function
// - Decode MAC registers at base plus offsets
// - 16-bit read high address latches, returns low
// - 16-bit read low address returns latched high
// - 16-bit write high address only latches low
// - 16-bit write low address commits all 32
// - Zero-quantum pause sent at next idle
// - Pause with programmed quantum at next idle
// - Back pressure forces collisions in half duplex
// - Counter write enable permits counter writes
// - Increment command bumps every counter once
// - Clear command zeroes all counters
// - Management disabled: MDIO released, MDC low
// - Control bits 31:13 read zero, ignored
// - Station address split low/high registers
// - Tx enable clear halts, flushes, rewinds
// - Rx enable gates frame reception
`timescale 1ns/1ns
`default_nettype none
`include "ecp_cfg.svh"

module ecp_mac_ctrl
	import ecp_pkg::*;
(
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	// Host bus
	input  wire logic [`ECP_ADDR_W-1:0] host_addr,
	input  wire logic [31:0]            host_wdata,
	input  wire logic                   host_wr,
	input  wire logic                   host_rd,
	input  wire logic                   bus_16bit,
	output logic      [31:0]            host_rdata,
	output logic                        host_ack,
	// MAC datapath status
	input  wire logic                   tx_idle,
	input  wire logic                   half_duplex,
	input  wire logic                   rx_frame_active,
	input  wire logic [`ECP_STAT_N-1:0] stat_event,
	input  wire logic [31:0]            mac_irq_src,
	input  wire logic [31:0]            tx_status_in,
	input  wire logic [15:0]            rx_pause_time_in,
	input  wire logic [31:0]            link_status_in,
	// MAC datapath control
	output logic                        tx_enable,
	output logic                        rx_enable,
	output logic                        tx_flush,
	output logic                        pause_send,
	output logic      [15:0]            pause_quantum,
	output logic                        force_collision,
	output logic      [47:0]            station_addr,
	output logic      [31:0]            net_config,
	// PHY management pins
	output logic                        mdc,
	output logic                        mdio_out,
	output logic                        mdio_oe,
	input  wire logic                   mdio_in
);
	localparam int MDC_HALF =
		(`ECP_MDC_HALF_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS;

	// Word offset match, used by the register write decoders below
	function automatic logic is_off(input logic [8:0] off,
		input logic [8:0] target);
		return off == target;
	endfunction

	logic [8:0]  off;
	logic        in_mac;
	logic        wr_go;
	logic [31:0] wd;
	logic [15:0] wlatch_reg;
	logic [31:0] rlatch_reg;
	logic        bp_reg;
	logic        stwe_reg;
	logic        mpe_reg;
	logic [31:0] irq_mask_reg;
	logic [31:0] sa_low_reg;
	logic [15:0] sa_high_reg;
	logic [15:0] txq_reg;
	logic        zpend_reg;
	logic        ppend_reg;
	logic        trig_zero;
	logic        trig_pause;
	logic        serve;
	logic        stat_wr;
	logic [31:0] stat_rdata;
	logic        rd_p1_reg;
	logic [8:0]  rd_off_reg;
	logic        rd_half_reg;
	logic        rd_16_reg;
	logic [31:0] rd_word;
	ecp_mgmt_state_t mg_state_reg;
	logic [31:0] mg_frame_reg;
	logic [5:0]  mg_bits_reg;
	logic [7:0]  mg_div_reg;

	// Address decode within the MAC window
	assign in_mac = host_addr[`ECP_ADDR_W-1:9] == `ECP_BASE_HI;
	assign off    = {host_addr[8:2], 2'b00};

	// A write lands on a full word, or on the low half-word in 16-bit mode
	assign wr_go = host_wr && in_mac && (!bus_16bit || !host_addr[1]);
	assign wd    = bus_16bit ? {host_wdata[15:0], wlatch_reg}
		: host_wdata;

	// Write latch takes the low half and holds it until the next one
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			wlatch_reg <= 16'h0;
		else if (host_wr && in_mac && bus_16bit && host_addr[1])
			wlatch_reg <= host_wdata[15:0];
	end

	// Control bits that software reads back
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bp_reg    <= 1'b0;
			stwe_reg  <= 1'b0;
			mpe_reg   <= 1'b0;
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
		end else if (wr_go && is_off(off, `ECP_OFF_CTRL)) begin
			bp_reg    <= wd[`ECP_CB_BP];
			stwe_reg  <= wd[`ECP_CB_STWE];
			mpe_reg   <= wd[`ECP_CB_MPE];
			tx_enable <= wd[`ECP_CB_TXEN];
			rx_enable <= wd[`ECP_CB_RXEN];
		end
	end

	// Flush pulse when the transmitter is switched off
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			tx_flush <= 1'b0;
		else
			tx_flush <= wr_go && is_off(off, `ECP_OFF_CTRL)
				&& tx_enable && !wd[`ECP_CB_TXEN];
	end

	// Pause triggers; the zero-quantum request is served first
	assign trig_zero  = wr_go && is_off(off, `ECP_OFF_CTRL)
		&& wd[`ECP_CB_ZPAUSE];
	assign trig_pause = wr_go && is_off(off, `ECP_OFF_CTRL)
		&& wd[`ECP_CB_PAUSE];
	assign serve = tx_idle && tx_enable && !pause_send
		&& (zpend_reg || ppend_reg);

	// A new trigger in the serve cycle stays pending; flush drops them
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			zpend_reg <= 1'b0;
			ppend_reg <= 1'b0;
		end else if (tx_flush) begin
			zpend_reg <= trig_zero;
			ppend_reg <= trig_pause;
		end else begin
			zpend_reg <= trig_zero || (zpend_reg && !serve);
			ppend_reg <= trig_pause
				|| (ppend_reg && !(serve && !zpend_reg));
		end
	end

	// Pause request to the transmitter, quantum beside it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pause_send    <= 1'b0;
			pause_quantum <= 16'h0;
		end else begin
			pause_send <= serve;
			if (serve)
				pause_quantum <= zpend_reg ? 16'h0 : txq_reg;
		end
	end

	// Collision forcing only in half duplex while a frame arrives
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			force_collision <= 1'b0;
		else
			force_collision <= bp_reg && half_duplex
				&& rx_frame_active && rx_enable;
	end

	// Configuration, interrupt enables, address and quantum registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			net_config   <= `ECP_CONFIG_RST;
			irq_mask_reg <= 32'h0;
			sa_low_reg   <= 32'h0;
			sa_high_reg  <= 16'h0;
			txq_reg      <= 16'h0;
		end else if (wr_go) begin
			if (is_off(off, `ECP_OFF_CONFIG))
				net_config <= wd;
			if (is_off(off, `ECP_OFF_IRQSET))
				irq_mask_reg <= irq_mask_reg | wd;
			if (is_off(off, `ECP_OFF_IRQCLR))
				irq_mask_reg <= irq_mask_reg & ~wd;
			if (is_off(off, `ECP_OFF_SA_LOW))
				sa_low_reg <= wd;
			if (is_off(off, `ECP_OFF_SA_HIGH))
				sa_high_reg <= wd[15:0];
			if (is_off(off, `ECP_OFF_TXQUANT))
				txq_reg <= wd[15:0];
		end
	end

	// Station address drive out follows the registers one cycle later
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			station_addr <= 48'h0;
		else
			station_addr <= {sa_high_reg, sa_low_reg};
	end

	// Counter bank; writes pass only while the test enable is set
	assign stat_wr = wr_go && off[8:5] == `ECP_STAT_HIT && stwe_reg;

	ecp_stat_mem u_stat (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clear_all (wr_go && is_off(off, `ECP_OFF_CTRL)
			&& wd[`ECP_CB_STCLR]),
		.inc_all   (wr_go && is_off(off, `ECP_OFF_CTRL)
			&& wd[`ECP_CB_STINC]),
		.wr_en     (stat_wr),
		.wr_idx    (off[4:2]),
		.wr_data   (wd),
		.rd_idx    (off[4:2]),
		.rd_data   (stat_rdata),
		.evt       (stat_event)
	);

	// PHY management shifter; disabling aborts any frame in flight
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mg_state_reg <= ECP_MG_IDLE;
			mg_frame_reg <= 32'h0;
			mg_bits_reg  <= 6'h0;
			mg_div_reg   <= 8'h0;
			mdc          <= 1'b0;
		end else if (!mpe_reg) begin
			mg_state_reg <= ECP_MG_IDLE;
			mdc          <= 1'b0;
			mg_div_reg   <= 8'h0;
		end else begin
			case (mg_state_reg)
			ECP_MG_IDLE: begin
				if (wr_go && is_off(off, `ECP_OFF_PHYMGMT)) begin
					mg_frame_reg <= wd;
					mg_bits_reg  <= `ECP_MGMT_BITS;
					mg_state_reg <= ECP_MG_SHIFT;
				end
			end
			ECP_MG_SHIFT: begin
				if (mg_div_reg == 8'(MDC_HALF - 1)) begin
					mg_div_reg <= 8'h0;
					mdc        <= !mdc;
					// Shift on the falling edge, sampling the PHY bit
					if (mdc) begin
						mg_frame_reg <= {mg_frame_reg[30:0], mdio_in};
						mg_bits_reg  <= mg_bits_reg - 6'h1;
						if (mg_bits_reg == 6'h1)
							mg_state_reg <= ECP_MG_IDLE;
					end
				end else begin
					mg_div_reg <= mg_div_reg + 8'h1;
				end
			end
			default: mg_state_reg <= ECP_MG_IDLE;
			endcase
		end
	end

	// MDIO pin drive; released whenever the port is disabled or idle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mdio_oe  <= 1'b0;
			mdio_out <= 1'b0;
		end else begin
			mdio_oe  <= mpe_reg && mg_state_reg == ECP_MG_SHIFT;
			mdio_out <= mg_frame_reg[31];
		end
	end

	// Read stage one: remember what was asked; counters read meanwhile
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_p1_reg   <= 1'b0;
			rd_off_reg  <= 9'h0;
			rd_half_reg <= 1'b0;
			rd_16_reg   <= 1'b0;
		end else begin
			rd_p1_reg   <= host_rd && in_mac;
			rd_off_reg  <= off;
			rd_half_reg <= host_addr[1];
			rd_16_reg   <= bus_16bit;
		end
	end

	// Read mux; unmapped offsets and write-only bits read as zero
	always_comb begin
		rd_word = 32'h0;
		if (rd_off_reg[8:5] == `ECP_STAT_HIT)
			rd_word = stat_rdata;
		else begin
			case (rd_off_reg)
			`ECP_OFF_CTRL: begin
				rd_word[`ECP_CB_BP]   = bp_reg;
				rd_word[`ECP_CB_STWE] = stwe_reg;
				rd_word[`ECP_CB_MPE]  = mpe_reg;
				rd_word[`ECP_CB_TXEN] = tx_enable;
				rd_word[`ECP_CB_RXEN] = rx_enable;
			end
			`ECP_OFF_CONFIG: rd_word = net_config;
			`ECP_OFF_STATUS: begin
				rd_word[`ECP_SB_MDIO] = mdio_in;
				rd_word[`ECP_SB_IDLE] = mg_state_reg == ECP_MG_IDLE;
			end
			`ECP_OFF_TXSTAT:  rd_word = tx_status_in;
			`ECP_OFF_IRQSTAT: rd_word = mac_irq_src;
			`ECP_OFF_IRQMASK: rd_word = irq_mask_reg;
			`ECP_OFF_PHYMGMT: rd_word = mg_frame_reg;
			`ECP_OFF_RXPAUSE: rd_word = {16'h0, rx_pause_time_in};
			`ECP_OFF_SA_LOW:  rd_word = sa_low_reg;
			`ECP_OFF_SA_HIGH: rd_word = {16'h0, sa_high_reg};
			`ECP_OFF_TXQUANT: rd_word = {16'h0, txq_reg};
			`ECP_OFF_LINKST:  rd_word = link_status_in;
			default:          rd_word = 32'h0;
			endcase
		end
	end

	// Read stage two: answer, with the half-word latch in 16-bit mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			host_rdata <= 32'h0;
			rlatch_reg <= 32'h0;
		end else if (rd_p1_reg) begin
			if (!rd_16_reg)
				host_rdata <= rd_word;
			else if (rd_half_reg) begin
				rlatch_reg <= rd_word;
				host_rdata <= {16'h0, rd_word[15:0]};
			end else
				host_rdata <= {16'h0, rlatch_reg[31:16]};
		end
	end

	// Ack: writes one cycle after the strobe, reads two cycles after
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			host_ack <= 1'b0;
		else
			host_ack <= rd_p1_reg || (host_wr && in_mac);
	end

	// Checks on the guarded behaviour
	a_mdc_disabled_low: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		!mpe_reg |=> !mdc && !mdio_oe)
		else $error("MDC or MDIO driven while port disabled");
	a_read_ack_two: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		host_rd && in_mac |-> ##2 host_ack)
		else $error("Read not acknowledged two cycles later");
	a_flush_on_txoff: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		wr_go && is_off(off, `ECP_OFF_CTRL) && tx_enable
		&& !wd[`ECP_CB_TXEN] |=> tx_flush && !tx_enable)
		else $error("Transmit disable did not flush");
	a_zero_pause_out: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		serve && zpend_reg |=> pause_send && pause_quantum == 16'h0)
		else $error("Zero pause not sent with zero quantum");
	a_pause_quantum: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		serve && !zpend_reg |=> pause_send
		&& pause_quantum == $past(txq_reg))
		else $error("Pause sent with wrong quantum");
	a_collision_force: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		bp_reg && half_duplex && rx_frame_active && rx_enable
		|=> force_collision)
		else $error("Collision not forced under back pressure");
	a_ctrl_upper_zero: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		rd_p1_reg && !rd_16_reg && is_off(rd_off_reg, `ECP_OFF_CTRL)
		|=> host_rdata[31:13] == 19'h0)
		else $error("Control upper bits read nonzero");
	a_half_read_pair: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		rd_p1_reg && rd_16_reg && !rd_half_reg
		|=> host_rdata == {16'h0, $past(rlatch_reg[31:16])})
		else $error("Low half-word read lost latched high bits");
	a_stat_wr_gate: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		wr_go && off[8:5] == `ECP_STAT_HIT && !stwe_reg
		&& !stat_event[off[4:2]]
		|=> u_stat.cnt_reg[$past(off[4:2])]
		== $past(u_stat.cnt_reg[off[4:2]]))
		else $error("Counter changed by a write without enable");
	a_sa_commit_16: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		wr_go && bus_16bit && is_off(off, `ECP_OFF_SA_LOW)
		|=> sa_low_reg == {$past(host_wdata[15:0]), $past(wlatch_reg)})
		else $error("16-bit write did not commit both halves");
endmodule // ecp_mac_ctrl
`default_nettype wire

// ### sim/ecp_phy_model.sv
// Far side of the MAC: transmitter timing, receive activity and the PHY.
// Assumes the control port drives pause_send as a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none

module ecp_phy_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Management pins
	input  wire logic        mdio_out,
	input  wire logic        mdio_oe,
	output logic             mdio_in,
	// Transmitter side
	input  wire logic        pause_send,
	input  wire logic [15:0] pause_quantum,
	input  wire logic        slow,
	output logic             tx_idle,
	output logic             rx_frame_active,
	output logic      [7:0]  pause_cnt,
	output logic      [15:0] qlog [0:7]
);
	logic [3:0] busy;

	// Pull-up holds a released MDIO line high
	assign mdio_in = mdio_oe ? mdio_out : 1'b1;
	assign tx_idle = (busy == 4'h0);

	// Each pause frame keeps the transmitter busy; slow stretches it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 4'h0;
			pause_cnt <= 8'h00;
			rx_frame_active <= 1'b0;
		end else begin
			rx_frame_active <= ~rx_frame_active;
			if (pause_send) begin
				busy <= slow ? 4'hc : 4'h4;
				qlog[pause_cnt[2:0]] <= pause_quantum;
				pause_cnt <= pause_cnt + 8'h01;
			end else if (busy != 4'h0) begin
				busy <= busy - 4'h1;
			end
		end
	end
endmodule // ecp_phy_model

`default_nettype wire

// ### sim/ethernet_mac_control_port_tb.sv
// Self-checking bench for the MAC control port.
// Assumes ecp_phy_model stands in for the transmitter and the PHY.
`timescale 1ns/1ns
`default_nettype none
`include "ecp_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module ethernet_mac_control_port_tb;
	import ecp_pkg::*;
	logic        sys_clk, reset_n, host_wr, host_rd, bus_16bit, host_ack;
	logic [19:0] host_addr;
	logic [31:0] host_wdata, host_rdata, mac_irq_src, tx_status_in;
	logic [31:0] link_status_in, net_config, seed, q, r, v;
	logic        tx_idle, half_duplex, rx_frame_active, mdio_in, slow, ok;
	logic [7:0]  stat_event, pause_cnt, b;
	logic [15:0] rx_pause_time_in, pause_quantum, lo, qlog [0:7];
	logic        tx_enable, rx_enable, tx_flush, pause_send, force_collision;
	logic        mdc, mdio_out, mdio_oe;
	logic [47:0] station_addr;
	int          fails, comparisons, flushes, n, k;

	ecp_mac_ctrl ecp_mac_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
		.host_rd(host_rd), .bus_16bit(bus_16bit), .host_rdata(host_rdata),
		.host_ack(host_ack), .tx_idle(tx_idle), .half_duplex(half_duplex),
		.rx_frame_active(rx_frame_active), .stat_event(stat_event),
		.mac_irq_src(mac_irq_src), .tx_status_in(tx_status_in),
		.rx_pause_time_in(rx_pause_time_in), .link_status_in(link_status_in),
		.tx_enable(tx_enable), .rx_enable(rx_enable), .tx_flush(tx_flush),
		.pause_send(pause_send), .pause_quantum(pause_quantum),
		.force_collision(force_collision), .station_addr(station_addr),
		.net_config(net_config), .mdc(mdc), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdio_in(mdio_in));

	ecp_phy_model ecp_phy_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in),
		.pause_send(pause_send), .pause_quantum(pause_quantum), .slow(slow),
		.tx_idle(tx_idle), .rx_frame_active(rx_frame_active),
		.pause_cnt(pause_cnt), .qlog(qlog));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// One host access; strobe lasts one cycle, answer awaited for 8 cycles
	task automatic acc(input logic wr, input logic [19:0] a,
		input logic [31:0] d);
		@(negedge sys_clk);
		host_addr = a;
		host_wdata = d;
		host_wr = wr;
		host_rd = !wr;
		@(negedge sys_clk);
		host_wr = 1'b0;
		host_rd = 1'b0;
		n = 0;
		while (host_ack !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		ok = (n < 8);
		q = host_rdata;
		if (a[19:9] == 11'h390) `CHK(ok, 1'b1)
		repeat (2) @(negedge sys_clk);
		seed = lfsr(seed);
	endtask

	task automatic stop_test;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) if (tx_flush === 1'b1) flushes++;

	initial begin
		repeat (50000) @(posedge sys_clk);
		fails++;
		stop_test();
	end

	initial begin
		{host_wr, host_rd, bus_16bit, half_duplex, slow} = 5'h00;
		{host_addr, host_wdata, stat_event} = 60'h0;
		{mac_irq_src, tx_status_in, link_status_in} = 96'h0;
		rx_pause_time_in = 16'h0;
		fails = 0;
		comparisons = 0;
		flushes = 0;
		seed = 32'h7bf0;
		reset_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		acc(0, 20'h72000, 0); `CHK(q, 32'h0)
		acc(0, 20'h72004, 0); `CHK(q, 32'h800)
		acc(0, 20'h72040, 0); `CHK(q, 32'h0)
		acc(0, 20'h70098, 0); `CHK(ok, 1'b0)
		// Read-only views follow their inputs
		mac_irq_src = seed;
		tx_status_in = ~seed;
		link_status_in = lfsr(seed);
		rx_pause_time_in = seed[27:12];
		acc(0, 20'h72024, 0); `CHK(q, mac_irq_src)
		acc(0, 20'h72014, 0); `CHK(q, tx_status_in)
		acc(0, 20'h720c0, 0); `CHK(q, link_status_in)
		acc(0, 20'h72038, 0); `CHK(q, {16'h0, rx_pause_time_in})
		acc(1, 20'h72028, 32'h0000_f0f3);
		acc(1, 20'h7202c, 32'h0000_0031);
		acc(0, 20'h72030, 0); `CHK(q, 32'h0000_f0c2)
		// Station address, with an out-of-window write that must miss
		r = seed;
		acc(1, 20'h72098, r);
		lo = seed[15:0];
		acc(1, 20'h7209c, {16'h0, lo});
		acc(1, 20'h70098, 32'hdead_0001);
		`CHK(station_addr, {lo, r})
		acc(0, 20'h72098, 0); `CHK(q, r)
		// Control readback keeps only the stored read/write fields
		for (k = 0; k < 4; k++) begin
			v = seed & ~32'h0000_1860;
			acc(1, 20'h72000, v);
			`CHK({tx_enable, rx_enable}, v[3:2])
			acc(0, 20'h72000, 0); `CHK(q, v & 32'h0000_019c)
		end
		// Statistics: clear, blocked write, enabled write, increment
		acc(1, 20'h72000, 32'h20);
		acc(0, 20'h72100, 0); `CHK(q, 32'h0)
		r = seed;
		acc(1, 20'h72104, r);
		acc(0, 20'h72104, 0); `CHK(q, 32'h0)
		acc(1, 20'h72000, 32'h80);
		acc(1, 20'h72104, r);
		acc(0, 20'h72104, 0); `CHK(q, r)
		acc(1, 20'h72000, 32'hc0);
		acc(0, 20'h72104, 0); `CHK(q, r + 32'h1)
		stat_event = 8'h80;
		@(negedge sys_clk);
		stat_event = 8'h00;
		acc(0, 20'h7211c, 0); `CHK(q, 32'h2)
		// Half-word accesses on a full-width register, others in between
		v = lfsr(seed);
		acc(1, 20'h72098, ~v);
		bus_16bit = 1'b1;
		lo = seed[15:0];
		acc(1, 20'h7209a, {seed[31:16], lo});
		bus_16bit = 1'b0;
		acc(0, 20'h72098, 0); `CHK(q, ~v)
		bus_16bit = 1'b1;
		acc(1, 20'h72098, v);
		bus_16bit = 1'b0;
		acc(0, 20'h72098, 0); `CHK(q, {v[15:0], lo})
		bus_16bit = 1'b1;
		acc(0, 20'h7209a, 0); `CHK(q, {16'h0, lo})
		bus_16bit = 1'b0;
		acc(1, 20'h72004, v); `CHK(net_config, v)
		acc(0, 20'h72004, 0); `CHK(q, v)
		bus_16bit = 1'b1;
		acc(0, 20'h72098, 0); `CHK(q, {16'h0, v[15:0]})
		bus_16bit = 1'b0;
		acc(1, 20'h720bc, {16'h0, lo});
		// Both pause triggers, prompt and slow transmitter
		for (k = 0; k < 2; k++) begin
			slow = k[0];
			b = pause_cnt;
			acc(1, 20'h72000, 32'h1808);
			repeat (60) @(negedge sys_clk);
			`CHK(pause_cnt, b + 8'h2)
			`CHK(qlog[b[2:0]], 16'h0)
			`CHK(qlog[b[2:0] + 3'h1], lo)
		end
		k = flushes;
		acc(1, 20'h72000, 32'h0);
		`CHK(flushes, k + 1)
		// Receive activity flips each cycle; the output shows the last beat
		acc(1, 20'h72000, 32'h104);
		for (k = 0; k < 4; k++) begin
			half_duplex = k[1];
			repeat (3) @(negedge sys_clk);
			`CHK(force_collision, k[1] & !rx_frame_active)
		end
		// Management port: disabled, running, then aborted
		acc(1, 20'h72000, 32'h0);
		acc(1, 20'h72034, seed);
		`CHK({mdc, mdio_oe}, 2'b00)
		acc(0, 20'h72008, 0); `CHK(q[2:1], 2'b11)
		acc(1, 20'h72000, 32'h10);
		v = seed;
		acc(1, 20'h72034, v);
		`CHK(mdio_oe, 1'b1)
		acc(0, 20'h72008, 0); `CHK(q[2], 1'b0)
		for (k = 0; k < 400 && q[2] !== 1'b1; k++) acc(0, 20'h72008, 0);
		`CHK(q[2], 1'b1)
		// Looped-back frame is home again after a full rotation
		acc(0, 20'h72034, 0); `CHK(q, v)
		acc(1, 20'h72034, seed);
		acc(1, 20'h72000, 32'h0);
		`CHK({mdc, mdio_oe}, 2'b00)
		stop_test();
	end
endmodule // ethernet_mac_control_port_tb

`default_nettype wire
